// >>> rtl/caco_top.sv
// Compare-driven outputs of the programmable counter array with register port
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module caco_top #(
  parameter int unsigned NUM_MODULES = 5  // Number of compare modules
) (
  input  wire logic                   clk,                   // System clock, 100 MHz
  input  wire logic                   arst_n,                // Asynchronous reset, active low
  input  wire logic                   counterTick,           // One-cycle tick for the array counter
  input  wire logic [7:0]             regAddr,               // Register address
  input  wire logic [7:0]             regWdata,              // Register write data
  input  wire logic                   regWr,                 // Write strobe
  input  wire logic                   regRd,                 // Read strobe
  output logic      [7:0]             regRdata,              // Read data, one cycle after the strobe
  output logic      [NUM_MODULES-1:0] moduleOutputPin,       // Module output pins
  output logic                        counterArrayInterrupt  // Level interrupt
);

  localparam int unsigned N = NUM_MODULES;

  typedef struct packed {
    logic                run;
    logic [N-1:0][7:0]   mode;
    logic [N-1:0][7:0]   cmpLo;
    logic [N-1:0][7:0]   cmpHi;
    logic [N-1:0]        suspend;
    logic [N-1:0]        flag;
    logic [N-1:0]        pin;
    logic [7:0]          rdata;
  } caco_state_t;

  caco_state_t cur;
  caco_state_t next_cur;

  logic [15:0]  arrayCount;
  logic         countStep;
  logic         countLowWrap;
  logic         wrCntLo;
  logic         wrCntHi;
  logic [N-1:0] match;
  logic [N-1:0] pwmLevel;
  logic [N-1:0] reload;
  logic [N-1:0] irqEnable;
  logic [7:0]   readValue;

  // Address of one register inside the window of module idx
  function automatic logic [7:0] modAddr(input int unsigned idx, input logic [7:0] ofs);
    logic [31:0] full;
    full = 32'(caco_pkg::OFS_MOD_BASE) + idx * 32'(caco_pkg::OFS_MOD_STRIDE) + 32'(ofs);
    return full[7:0];
  endfunction

  // Counter byte loads from software
  assign wrCntLo = regWr && (regAddr == caco_pkg::OFS_CNT_LO);
  assign wrCntHi = regWr && (regAddr == caco_pkg::OFS_CNT_HI);

  // The one shared array counter
  caco_counter u_counter (
    .clk     (clk),
    .arst_n  (arst_n),
    .run     (cur.run),
    .tick    (counterTick),
    .wrLo    (wrCntLo),
    .wrHi    (wrCntHi),
    .wdata   (regWdata),
    .count   (arrayCount),
    .step    (countStep),
    .lowWrap (countLowWrap)
  );

  // One comparator per module, all fed by the same counter
  for (genvar g = 0; g < N; g++) begin : gen_cmp
    caco_compare u_cmp (
      .count    (arrayCount),
      .step     (countStep),
      .lowWrap  (countLowWrap),
      .mode     (cur.mode[g]),
      .cmpLo    (cur.cmpLo[g]),
      .cmpHi    (cur.cmpHi[g]),
      .suspend  (cur.suspend[g]),
      .match    (match[g]),
      .pwmLevel (pwmLevel[g]),
      .reload   (reload[g])
    );
    assign irqEnable[g] = cur.mode[g][caco_pkg::MODE_IRQ_EN_BIT];
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    readValue = 8'h00;
    case (regAddr)
      caco_pkg::OFS_CTRL: begin
        readValue[caco_pkg::CTRL_RUN_BIT] = cur.run;
      end
      caco_pkg::OFS_CNT_LO: begin
        readValue = arrayCount[7:0];
      end
      caco_pkg::OFS_CNT_HI: begin
        readValue = arrayCount[15:8];
      end
      caco_pkg::OFS_IRQ_STAT: begin
        readValue[N-1:0] = cur.flag;
      end
      caco_pkg::OFS_IRQ_MASK: begin
        readValue[N-1:0] = irqEnable;
      end
      default: begin
        for (int unsigned i = 0; i < N; i++) begin
          if (regAddr == modAddr(i, caco_pkg::OFS_MOD_MODE)) begin
            readValue = cur.mode[i];
          end
          if (regAddr == modAddr(i, caco_pkg::OFS_MOD_CMP_LO)) begin
            readValue = cur.cmpLo[i];
          end
          if (regAddr == modAddr(i, caco_pkg::OFS_MOD_CMP_HI)) begin
            readValue = cur.cmpHi[i];
          end
        end
      end
    endcase
  end

  // Next state of registers, flags and pins
  always_comb begin
    next_cur = cur;

    // Read data stands only in the cycle after the strobe
    next_cur.rdata = regRd ? readValue : 8'h00;

    // Control register
    if (regWr && (regAddr == caco_pkg::OFS_CTRL)) begin
      next_cur.run = regWdata[caco_pkg::CTRL_RUN_BIT];
    end

    for (int unsigned i = 0; i < N; i++) begin
      // Mode register, capture bits not kept
      if (regWr && (regAddr == modAddr(i, caco_pkg::OFS_MOD_MODE))) begin
        next_cur.mode[i] = regWdata & caco_pkg::MODE_WR_MASK;
      end

      // Mask register is a second view of the per-module enables
      if (regWr && (regAddr == caco_pkg::OFS_IRQ_MASK)) begin
        next_cur.mode[i][caco_pkg::MODE_IRQ_EN_BIT] = regWdata[i];
      end

      // Compare low write holds the comparator off
      if (regWr && (regAddr == modAddr(i, caco_pkg::OFS_MOD_CMP_LO))) begin
        next_cur.cmpLo[i] = regWdata;
        next_cur.suspend[i] = 1'b1;
      end else if (reload[i]) begin
        next_cur.cmpLo[i] = cur.cmpHi[i];
      end

      // Compare high write lets the comparator run again
      if (regWr && (regAddr == modAddr(i, caco_pkg::OFS_MOD_CMP_HI))) begin
        next_cur.cmpHi[i] = regWdata;
        next_cur.suspend[i] = 1'b0;
      end

      // Event flag: write one clears, a match in the same cycle wins
      if (regWr && (regAddr == caco_pkg::OFS_IRQ_STAT) && regWdata[i]) begin
        next_cur.flag[i] = 1'b0;
      end
      if (match[i] && cur.mode[i][caco_pkg::MODE_MAT_BIT]) begin
        next_cur.flag[i] = 1'b1;
      end

      // Pin: pulse width level, toggle on match, or hold
      if (cur.mode[i][caco_pkg::MODE_PWM_BIT] && cur.mode[i][caco_pkg::MODE_COMPARATOR_ENABLE_BIT]) begin
        next_cur.pin[i] = pwmLevel[i];
      end else if (match[i] && cur.mode[i][caco_pkg::MODE_TOG_BIT]
                   && cur.mode[i][caco_pkg::MODE_MAT_BIT]) begin
        next_cur.pin[i] = !cur.pin[i];
      end else begin
        next_cur.pin[i] = cur.pin[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur.run <= 1'b0;
      cur.mode <= {N{caco_pkg::MODE_RST}};
      cur.cmpLo <= {N{caco_pkg::CMP_RST}};
      cur.cmpHi <= {N{caco_pkg::CMP_RST}};
      cur.suspend <= '0;
      cur.flag <= '0;
      cur.pin <= {N{caco_pkg::PIN_RST}};
      cur.rdata <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign regRdata = cur.rdata;
  assign moduleOutputPin = cur.pin;
  assign counterArrayInterrupt = |(cur.flag & irqEnable);

endmodule

`default_nettype wire

// >>> rtl/caco_pkg.sv
// Shared constants of the counter array compare outputs block
package caco_pkg;

  // Register bus widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // Block level register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CNT_LO   = 8'h04;
  localparam logic [7:0] OFS_CNT_HI   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Per-module register window: base + index * stride + offset
  localparam logic [7:0] OFS_MOD_BASE   = 8'h20;
  localparam logic [7:0] OFS_MOD_STRIDE = 8'h10;
  localparam logic [7:0] OFS_MOD_MODE   = 8'h00;
  localparam logic [7:0] OFS_MOD_CMP_LO = 8'h04;
  localparam logic [7:0] OFS_MOD_CMP_HI = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_RUN_BIT = 0;

  // Module mode register fields
  localparam int unsigned MODE_IRQ_EN_BIT = 0;
  localparam int unsigned MODE_PWM_BIT    = 1;
  localparam int unsigned MODE_TOG_BIT    = 2;
  localparam int unsigned MODE_MAT_BIT    = 3;
  localparam int unsigned MODE_COMPARATOR_ENABLE_BIT   = 6;
  localparam logic [7:0]  MODE_WR_MASK    = 8'h4f;

  // Reset values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  CMP_RST  = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic        PIN_RST  = 1'b0;

  // Low byte value that ends one pulse width period of 256 ticks
  localparam logic [7:0] LOW_BYTE_LAST = 8'hff;

endpackage

// >>> rtl/caco_counter.sv
// Shared 16-bit array counter with tick stepping and software load
`timescale 1ns/1ps
`default_nettype none

module caco_counter (
  input  wire logic        clk,      // System clock
  input  wire logic        arst_n,   // Asynchronous reset, active low
  input  wire logic        run,      // Counting enabled
  input  wire logic        tick,     // One-cycle tick from the shared timer
  input  wire logic        wrLo,     // Load low byte
  input  wire logic        wrHi,     // Load high byte
  input  wire logic [7:0]  wdata,    // Load value
  output logic      [15:0] count,    // Counter value
  output logic             step,     // Counter advanced this cycle
  output logic             lowWrap   // Low byte went from 255 to 00 this cycle
);

  typedef struct packed {
    logic [15:0] count;
    logic        step;
    logic        lowWrap;
  } caco_cnt_state_t;

  caco_cnt_state_t cur;
  caco_cnt_state_t next_cur;

  // Next state: software load wins over a tick in the same cycle
  always_comb begin
    next_cur = cur;
    next_cur.step = 1'b0;
    next_cur.lowWrap = 1'b0;
    if (wrLo) begin
      next_cur.count[7:0] = wdata;
    end else if (wrHi) begin
      next_cur.count[15:8] = wdata;
    end else if (run && tick) begin
      next_cur.count = cur.count + 16'h0001;
      next_cur.step = 1'b1;
      next_cur.lowWrap = (cur.count[7:0] == caco_pkg::LOW_BYTE_LAST);
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '{count: caco_pkg::CNT_RST, step: 1'b0, lowWrap: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign count = cur.count;
  assign step = cur.step;
  assign lowWrap = cur.lowWrap;

endmodule

`default_nettype wire

// >>> rtl/caco_compare.sv
// Per-module comparator: match pulse, pulse width level and duty reload
`timescale 1ns/1ps
`default_nettype none

module caco_compare (
  input  wire logic [15:0] count,     // Shared array counter
  input  wire logic        step,      // Counter advanced this cycle
  input  wire logic        lowWrap,   // Low byte wrapped this cycle
  input  wire logic [7:0]  mode,      // Module mode register
  input  wire logic [7:0]  cmpLo,     // Compare low byte
  input  wire logic [7:0]  cmpHi,     // Compare high byte
  input  wire logic        suspend,   // Comparator held off by a low byte write
  output logic             match,     // Counter just reached the compare value
  output logic             pwmLevel,  // Pulse width level for this counter value
  output logic             reload     // Copy high byte into low byte now
);

  logic       compareOn;
  logic [7:0] pwmRef;

  // Comparator runs only while enabled and not mid-update
  assign compareOn = mode[caco_pkg::MODE_COMPARATOR_ENABLE_BIT] && !suspend;

  // One pulse per arrival at the compare value, also after each wrap
  assign match = compareOn && step && (count == {cmpHi, cmpLo});

  // Duty copy happens only at the 255 to 00 boundary
  assign reload = mode[caco_pkg::MODE_PWM_BIT] && mode[caco_pkg::MODE_COMPARATOR_ENABLE_BIT] && lowWrap;

  // Use the fresh duty in the very first count of the new period
  assign pwmRef = reload ? cmpHi : cmpLo;
  assign pwmLevel = (count[7:0] >= pwmRef);

endmodule

`default_nettype wire

// >>> verification/caco_top_assertions.sv
// Port checker of the counter array compare outputs
`timescale 1ns/1ps
`default_nettype none

module caco_top_assertions #(
  parameter int unsigned NUM_MODULES = 5  // Module count
) (
  input wire logic                   clk,                   // Clock
  input wire logic                   arst_n,                // Reset
  input wire logic                   counterTick,           // Tick
  input wire logic [7:0]             regAddr,               // Address
  input wire logic [7:0]             regWdata,              // Write data
  input wire logic                   regWr,                 // Write strobe
  input wire logic                   regRd,                 // Read strobe
  input wire logic [7:0]             regRdata,              // Read data
  input wire logic [NUM_MODULES-1:0] moduleOutputPin,       // Pins
  input wire logic                   counterArrayInterrupt  // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] cnt;
  logic [7:0]  m0, lo0, hi0;
  logic        run, stepped, sus0;
  wire         pin0  = moduleOutputPin[0];
  wire         wrCnt = regWr && (regAddr == caco_pkg::OFS_CNT_LO || regAddr == caco_pkg::OFS_CNT_HI);
  wire         hso   = m0[caco_pkg::MODE_TOG_BIT] && m0[caco_pkg::MODE_MAT_BIT] && m0[caco_pkg::MODE_COMPARATOR_ENABLE_BIT]
                       && !m0[caco_pkg::MODE_PWM_BIT];
  wire         hit   = hso && !sus0 && stepped && cnt == {hi0, lo0};

  // Shadow of the counter and of module 0 settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cnt, m0, lo0, hi0, run, stepped, sus0} <= '0;
    end else begin
      stepped <= run && counterTick && !wrCnt;
      if (regWr && regAddr == caco_pkg::OFS_CTRL) run <= regWdata[caco_pkg::CTRL_RUN_BIT];
      if (regWr && regAddr == caco_pkg::OFS_CNT_LO) cnt[7:0] <= regWdata;
      if (regWr && regAddr == caco_pkg::OFS_CNT_HI) cnt[15:8] <= regWdata;
      if (run && counterTick && !wrCnt) cnt <= cnt + 16'h0001;
      if (regWr && regAddr == caco_pkg::OFS_MOD_BASE) m0 <= regWdata & caco_pkg::MODE_WR_MASK;
      if (regWr && regAddr == caco_pkg::OFS_IRQ_MASK) m0[0] <= regWdata[0];
      if (regWr && regAddr == caco_pkg::OFS_MOD_BASE + caco_pkg::OFS_MOD_CMP_LO) {lo0, sus0} <= {regWdata, 1'b1};
      if (regWr && regAddr == caco_pkg::OFS_MOD_BASE + caco_pkg::OFS_MOD_CMP_HI) {hi0, sus0} <= {regWdata, 1'b0};
    end
  end

  sequence readOf(logic [7:0] a);
    regRd && regAddr == a;
  endsequence
  sequence hsoHit;
    hit;
  endsequence

  // Read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("read data outside read");
  a_cnt_lo_read: assert property (readOf(caco_pkg::OFS_CNT_LO) |=>
    {8'h00, regRdata} == ($past(cnt) & 16'h00ff)) else $error("counter low byte wrong");
  a_cnt_hi_read: assert property (readOf(caco_pkg::OFS_CNT_HI) |=>
    {regRdata, 8'h00} == ($past(cnt) & 16'hff00)) else $error("counter high byte wrong");
  a_mode_read: assert property (readOf(caco_pkg::OFS_MOD_BASE) |=>
    regRdata == $past(m0)) else $error("mode readback wrong");
  a_hso_toggle: assert property (hsoHit |=> pin0 != $past(pin0)) else $error("no toggle on match");
  a_hso_hold: assert property ($changed(pin0) && $past(hso) && hso |-> $past(hit))
    else $error("pin moved without match");
  a_reset_low: assert property ($rose(arst_n) |-> moduleOutputPin == '0 && !counterArrayInterrupt)
    else $error("outputs not cleared by reset");
  a_irq_rise: assert property ($rose(counterArrayInterrupt) |-> $past(counterTick, 2) || $past(regWr))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(counterArrayInterrupt) |-> $past(regWr))
    else $error("interrupt fell without write");
endmodule

`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench of the counter array compare outputs
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int unsigned NM   = 5;
  localparam logic [7:0]  CTRL = caco_pkg::OFS_CTRL;
  localparam logic [7:0]  CLO  = caco_pkg::OFS_CNT_LO;
  localparam logic [7:0]  CHI  = caco_pkg::OFS_CNT_HI;
  localparam logic [7:0]  STAT = caco_pkg::OFS_IRQ_STAT;
  localparam logic [7:0]  MD   = caco_pkg::OFS_MOD_MODE;
  localparam logic [7:0]  LO   = caco_pkg::OFS_MOD_CMP_LO;
  localparam logic [7:0]  HI   = caco_pkg::OFS_MOD_CMP_HI;
  localparam logic [7:0]  HSO  = 8'((1 << caco_pkg::MODE_TOG_BIT) | (1 << caco_pkg::MODE_MAT_BIT)
                                    | (1 << caco_pkg::MODE_COMPARATOR_ENABLE_BIT));
  localparam logic [7:0]  PWM  = 8'((1 << caco_pkg::MODE_PWM_BIT) | (1 << caco_pkg::MODE_COMPARATOR_ENABLE_BIT));
  logic          clk, arst_n, counterTick, regWr, regRd, irq;
  logic [7:0]    regAddr, regWdata, regRdata;
  logic [NM-1:0] pins;
  int            error_cnt, tests_run, highs;

  caco_top #(.NUM_MODULES(NM)) caco_top_inst (
    .clk(clk), .arst_n(arst_n), .counterTick(counterTick), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .moduleOutputPin(pins), .counterArrayInterrupt(irq));

  function automatic logic [7:0] ma(input int i, input logic [7:0] ofs);
    return caco_pkg::OFS_MOD_BASE + 8'(i) * caco_pkg::OFS_MOD_STRIDE + ofs;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk({8'h00, regRdata}, {8'h00, exp});
  endtask
  // Holds the tick high for n counted cycles
  task automatic tick(input int n);
    @(posedge clk);
    counterTick <= 1'b1;
    repeat (n) @(posedge clk);
    counterTick <= 1'b0;
  endtask
  // Lets the match and the pin register land
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hang short
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
  // Main sequence
  initial begin
    {arst_n, counterTick, regWr, regRd, regAddr, regWdata} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'hff, 8'h00);
    chk(16'(pins), 16'h0000);
    wr(CLO, 8'hfe);
    wr(CHI, 8'h12);
    wr(CTRL, 8'h01);
    tick(3);
    rd(CLO, 8'h01);
    rd(CHI, 8'h13);
    wr(CTRL, 8'h00);
    tick(2);
    rd(CLO, 8'h01);
    // High-speed output on module 0, its interrupt off and then enabled through the mask
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(ma(0, LO), 8'h05);
    wr(ma(0, HI), 8'h00);
    wr(ma(0, MD), HSO);
    rd(ma(0, MD), HSO);
    wr(CTRL, 8'h01);
    tick(4);
    settle();
    chk(16'(pins[0]), 16'h0000);
    tick(1);
    settle();
    chk(16'(pins[0]), 16'h0001);
    chk(16'(irq), 16'h0000);
    rd(STAT, 8'h01);
    tick(1);
    settle();
    chk(16'(pins[0]), 16'h0001);
    wr(CLO, 8'hfe);
    wr(CHI, 8'hff);
    tick(7);
    settle();
    chk(16'(pins[0]), 16'h0000);
    wr(caco_pkg::OFS_IRQ_MASK, 8'h01);
    settle();
    chk(16'(irq), 16'h0001);
    rd(caco_pkg::OFS_IRQ_MASK, 8'h01);
    wr(STAT, 8'h01);
    settle();
    chk(16'(irq), 16'h0000);
    // Low byte write alone holds the comparator off
    wr(ma(0, LO), 8'h08);
    tick(3);
    settle();
    chk(16'(pins[0]), 16'h0000);
    wr(ma(0, HI), 8'h00);
    wr(CLO, 8'h07);
    tick(1);
    settle();
    chk(16'(pins[0]), 16'h0001);
    chk(16'(irq), 16'h0001);
    wr(STAT, 8'h01);
    // Pulse width on module 1, duty one quarter low
    wr(CTRL, 8'h00);
    wr(CLO, 8'hf0);
    wr(CHI, 8'h00);
    wr(ma(1, LO), 8'h00);
    wr(ma(1, HI), 8'h40);
    wr(ma(1, MD), PWM);
    wr(CTRL, 8'h01);
    tick(5);
    settle();
    chk(16'(pins[1]), 16'h0001);
    tick(11);
    settle();
    chk(16'(pins[1]), 16'h0000);
    rd(ma(1, LO), 8'h40);
    tick(63);
    settle();
    chk(16'(pins[1]), 16'h0000);
    tick(1);
    settle();
    chk(16'(pins[1]), 16'h0001);
    highs = 0;
    repeat (256) begin
      tick(1);
      settle();
      highs += int'(pins[1]);
    end
    chk(16'(highs), 16'd192);
    test_done();
  end
endmodule

bind caco_top caco_top_assertions #(.NUM_MODULES(NUM_MODULES)) caco_top_assertions_inst (
  .clk(clk), .arst_n(arst_n), .counterTick(counterTick), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .moduleOutputPin(moduleOutputPin),
  .counterArrayInterrupt(counterArrayInterrupt));

`default_nettype wire
